// *** core/watchdog_pkg.sv ***
// constants and types for the watchdog control block
// Contract
// - Bit 0 of the control register is a read/write status flag: set by a timeout, cleared only by writing zero to it.
// - Writing one to bit 2 raises a timeout event at once, and the bit clears itself.
// - With bit 3 set, each rising edge of the keyboard force line raises a timeout event.
// - With bit 3 clear, the keyboard force line never raises a timeout event.
// - The timeout request is the OR of the software force, the keyboard edge pulse and the counter expiry.
// - A keyboard line high from 1us to forever gives exactly one event per rising edge.
// - Bits 7 to 4 of the control register are reserved, written as zero and without function.
// - A timeout value of zero disables counted timeouts; other values give the length in units.
// - Bit 7 of the units register selects seconds when one and minutes when zero, the default.
package watchdog_pkg;
	// register indices; byte address is four times the index
	localparam logic [7:0] REG_UNITS_IDX = 8'hf1;
	localparam logic [7:0] REG_VALUE_IDX = 8'hf2;
	localparam logic [7:0] REG_CTRL_IDX = 8'hf4;
	localparam logic [7:0] REG_IRQ_STS_IDX = 8'hf8;
	localparam logic [7:0] REG_IRQ_MASK_IDX = 8'hf9;
	localparam logic [7:0] UNITS_RESET = 8'h00;
	localparam logic [7:0] VALUE_RESET = 8'h00;
	localparam logic [7:0] VALUE_DISABLED = 8'h00;
	localparam logic [7:0] VALUE_LAST = 8'h01;
	localparam logic [1:0] IRQ_RESET = 2'h0;
	localparam logic [3:0] CTRL_RSVD_VAL = 4'h0;
	localparam int CTRL_STATUS_BIT = 0;
	localparam int CTRL_FORCE_BIT = 2;
	localparam int CTRL_KBD_EN_BIT = 3;
	localparam int UNITS_SEC_BIT = 7;
	localparam int IRQ_TIMEOUT_BIT = 0;
	localparam int IRQ_KBD_BIT = 1;
	localparam int IRQ_BITS = 2;
	// timing at a 20 MHz reference
	localparam int CLK_PERIOD_NS = 50;
	localparam int SEC_NS = 1_000_000_000;
	localparam int SEC_CYCLES = SEC_NS / CLK_PERIOD_NS;
	localparam int KBD_MIN_HIGH_NS = 1000;
	localparam int KBD_MIN_HIGH_CYCLES = (KBD_MIN_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [5:0] SEC_PER_MIN_LAST = 6'h3b;
	localparam int PRESCALE_W = 25;
	typedef struct packed {
		logic [3:0] rsvd_hi;
		logic kbd_en;
		logic force_to;
		logic rsvd1;
		logic status;
	} ctrl_t;
	localparam ctrl_t CTRL_RESET = '{4'h0, 1'b0, 1'b0, 1'b0, 1'b0};
	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_ACK = 2'b10
	} bus_state_t;
endpackage

// *** core/keyboard_edge_detect.sv ***
// synchronised rising-edge detector for the keyboard force line
`timescale 1ns/1ps
`default_nettype none
module keyboard_edge_detect (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic srst_i,
	// line and gate
	input wire logic keyboard_force_line_i,
	input wire logic enable_i,
	// one-cycle event
	output logic pulse_o
);
	import watchdog_pkg::*;

	logic meta_ff;
	logic sync_ff;
	logic prev_ff;
	logic pulse_ff;

	// first stage feeds only the second
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			meta_ff <= 1'b0;
			sync_ff <= 1'b0;
			prev_ff <= 1'b0;
		end else begin
			meta_ff <= keyboard_force_line_i;
			sync_ff <= meta_ff;
			prev_ff <= sync_ff;
		end
	end

	// edge, not level: a line held high fires once
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			pulse_ff <= 1'b0;
		end else begin
			pulse_ff <= enable_i && sync_ff && !prev_ff;
		end
	end

	assign pulse_o = pulse_ff;

	kbd_edge_fire_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		enable_i && sync_ff && !prev_ff |=> pulse_o)
		else $error("keyboard edge gave no event");
	kbd_disabled_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		pulse_o |-> $past(enable_i))
		else $error("event while keyboard line disabled");
	kbd_single_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		pulse_o |=> !pulse_o ##1 !pulse_o)
		else $error("more than one event per edge");
endmodule
`default_nettype wire

// *** core/watchdog_counter.sv ***
// timeout counter with seconds prescaler and minute divider
`timescale 1ns/1ps
`default_nettype none
module watchdog_counter #(
	parameter int SEC_CYCLES_P = watchdog_pkg::SEC_CYCLES
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic srst_i,
	// setup
	input wire logic load_i,
	input wire logic [7:0] value_i,
	input wire logic unit_sec_i,
	// status
	output logic expire_o
);
	import watchdog_pkg::*;

	localparam logic [PRESCALE_W-1:0] PRESC_LAST = PRESCALE_W'(SEC_CYCLES_P - 1);

	logic [PRESCALE_W-1:0] presc_ff;
	logic [5:0] min_cnt_ff;
	logic [7:0] remain_ff;
	logic expire_ff;
	logic sec_tick;
	logic min_tick;
	logic step;

	assign sec_tick = (presc_ff == PRESC_LAST);
	assign min_tick = sec_tick && (min_cnt_ff == SEC_PER_MIN_LAST);
	assign step = unit_sec_i ? sec_tick : min_tick;

	// reload restarts the time base so the first unit is whole
	always_ff @(posedge ref_clk_i) begin
		if (srst_i || load_i || sec_tick) begin
			presc_ff <= '0;
		end else begin
			presc_ff <= presc_ff + 1'b1;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (srst_i || load_i || min_tick) begin
			min_cnt_ff <= 6'h00;
		end else if (sec_tick) begin
			min_cnt_ff <= min_cnt_ff + 6'h01;
		end
	end

	// zero never reaches the last count, so it never expires
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			remain_ff <= VALUE_RESET;
			expire_ff <= 1'b0;
		end else if (load_i) begin
			remain_ff <= value_i;
			expire_ff <= 1'b0;
		end else begin
			expire_ff <= step && (remain_ff == VALUE_LAST);
			if (step && remain_ff != VALUE_DISABLED) begin
				remain_ff <= remain_ff - 8'h01;
			end
		end
	end

	assign expire_o = expire_ff;

	cnt_disabled_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		expire_o |-> $past(remain_ff) == VALUE_LAST)
		else $error("expiry without last count");
	cnt_minute_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		!unit_sec_i && step |-> min_cnt_ff == SEC_PER_MIN_LAST && sec_tick)
		else $error("minute step off the minute boundary");
endmodule
`default_nettype wire

// *** core/watchdog_control_register.sv ***
// watchdog control, status and interrupt registers on an avalon slave
`timescale 1ns/1ps
`default_nettype none
module watchdog_control_register #(
	parameter int SEC_CYCLES_P = watchdog_pkg::SEC_CYCLES
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic srst_i,
	// avalon-mm slave, word address
	input wire logic [7:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// keyboard controller line
	input wire logic keyboard_force_line_i,
	// events
	output logic timeout_o,
	output logic irq_o
);
	import watchdog_pkg::*;

	bus_state_t bus_state_ff;
	logic waitreq_ff;
	logic [31:0] readdata_ff;
	ctrl_t ctrl_ff;
	logic [7:0] units_ff;
	logic [7:0] value_ff;
	logic [IRQ_BITS-1:0] irq_sts_ff;
	logic [IRQ_BITS-1:0] irq_mask_ff;
	logic irq_ff;
	logic timeout_ff;
	logic force_ff;
	logic [7:0] rd_mux;
	logic wr_take;
	logic wr_ctrl;
	logic wr_units;
	logic wr_value;
	logic wr_sts;
	logic wr_mask;
	logic kbd_pulse;
	logic expire;
	logic timeout_evt;
	logic [IRQ_BITS-1:0] irq_evt;
	logic [7:0] wbyte;

	// bus handshake

	// one wait state: request seen, then answered for a single cycle
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			bus_state_ff <= BUS_IDLE;
			waitreq_ff <= 1'b1;
		end else begin
			unique case (bus_state_ff)
				BUS_IDLE: begin
					if (avs_read_i || avs_write_i) begin
						bus_state_ff <= BUS_ACK;
						waitreq_ff <= 1'b0;
					end
				end
				BUS_ACK: begin
					bus_state_ff <= BUS_IDLE;
					waitreq_ff <= 1'b1;
				end
				default: begin
					bus_state_ff <= BUS_IDLE;
					waitreq_ff <= 1'b1;
				end
			endcase
		end
	end

	// upper byte lanes carry nothing; lane 0 gates every write
	assign wbyte = avs_writedata_i[7:0];
	assign wr_take = (bus_state_ff == BUS_ACK) && avs_write_i && avs_byteenable_i[0];
	assign wr_ctrl = wr_take && (avs_address_i == REG_CTRL_IDX);
	assign wr_units = wr_take && (avs_address_i == REG_UNITS_IDX);
	assign wr_value = wr_take && (avs_address_i == REG_VALUE_IDX);
	assign wr_sts = wr_take && (avs_address_i == REG_IRQ_STS_IDX);
	assign wr_mask = wr_take && (avs_address_i == REG_IRQ_MASK_IDX);

	// read mux; unmapped indices read zero
	always_comb begin
		rd_mux = 8'h00;
		unique case (avs_address_i)
			REG_UNITS_IDX: rd_mux = units_ff;
			REG_VALUE_IDX: rd_mux = value_ff;
			REG_CTRL_IDX: rd_mux = ctrl_ff; // force bit always reads zero
			REG_IRQ_STS_IDX: rd_mux = {6'h00, irq_sts_ff};
			REG_IRQ_MASK_IDX: rd_mux = {6'h00, irq_mask_ff};
			default: rd_mux = 8'h00;
		endcase
	end

	// data captured as waitrequest drops, stands through the answer
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			readdata_ff <= 32'h0000_0000;
		end else if (bus_state_ff == BUS_IDLE && avs_read_i) begin
			readdata_ff <= {24'h00_0000, rd_mux};
		end
	end

	assign avs_readdata_o = readdata_ff;
	assign avs_waitrequest_o = waitreq_ff;

	// timing registers

	// only the unit select bit exists; the rest read zero
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			units_ff <= UNITS_RESET;
		end else if (wr_units) begin
			units_ff <= 8'h00;
			units_ff[UNITS_SEC_BIT] <= wbyte[UNITS_SEC_BIT];
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			value_ff <= VALUE_RESET;
		end else if (wr_value) begin
			value_ff <= wbyte;
		end
	end

	// writing the value is the restart; nothing else reloads the counter
	watchdog_counter #(
		.SEC_CYCLES_P(SEC_CYCLES_P)
	) u_counter (
		.ref_clk_i(ref_clk_i),
		.srst_i(srst_i),
		.load_i(wr_value),
		.value_i(wbyte),
		.unit_sec_i(units_ff[UNITS_SEC_BIT]),
		.expire_o(expire)
	);

	// force sources

	keyboard_edge_detect u_kbd_edge (
		.ref_clk_i(ref_clk_i),
		.srst_i(srst_i),
		.keyboard_force_line_i(keyboard_force_line_i),
		.enable_i(ctrl_ff.kbd_en),
		.pulse_o(kbd_pulse)
	);

	// self-clearing: a one-cycle pulse, never stored in the register
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			force_ff <= 1'b0;
		end else begin
			force_ff <= wr_ctrl && wbyte[CTRL_FORCE_BIT];
		end
	end

	assign timeout_evt = force_ff || kbd_pulse || expire;

	// control register

	// an event in the clearing cycle wins over the clear
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			ctrl_ff <= CTRL_RESET;
		end else begin
			if (timeout_evt) begin
				ctrl_ff.status <= 1'b1;
			end else if (wr_ctrl) begin
				ctrl_ff.status <= wbyte[CTRL_STATUS_BIT];
			end
			if (wr_ctrl) begin
				ctrl_ff.kbd_en <= wbyte[CTRL_KBD_EN_BIT];
			end
			ctrl_ff.force_to <= 1'b0;
			ctrl_ff.rsvd1 <= 1'b0;
			ctrl_ff.rsvd_hi <= CTRL_RSVD_VAL;
		end
	end

	// interrupt status and mask

	assign irq_evt[IRQ_TIMEOUT_BIT] = timeout_evt;
	assign irq_evt[IRQ_KBD_BIT] = kbd_pulse;

	// write one to clear; set wins
	for (genvar i = 0; i < IRQ_BITS; i++) begin : g_irq
		always_ff @(posedge ref_clk_i) begin
			if (srst_i) begin
				irq_sts_ff[i] <= IRQ_RESET[i];
			end else if (irq_evt[i]) begin
				irq_sts_ff[i] <= 1'b1;
			end else if (wr_sts && wbyte[i]) begin
				irq_sts_ff[i] <= 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			irq_mask_ff <= IRQ_RESET;
		end else if (wr_mask) begin
			irq_mask_ff <= wbyte[IRQ_BITS-1:0];
		end
	end

	// registered output costs one cycle of latency after the status bit
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			irq_ff <= 1'b0;
			timeout_ff <= 1'b0;
		end else begin
			irq_ff <= |(irq_sts_ff & irq_mask_ff);
			timeout_ff <= timeout_evt;
		end
	end

	assign irq_o = irq_ff;
	assign timeout_o = timeout_ff;

	// checks

	status_set_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		timeout_evt |=> ctrl_ff.status ##0 timeout_o)
		else $error("timeout did not set status");
	force_pulse_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		wr_ctrl && wbyte[CTRL_FORCE_BIT] |=> force_ff && !ctrl_ff.force_to ##1 !force_ff)
		else $error("force bit not a single self-clearing pulse");
	event_or_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		force_ff || kbd_pulse |=> timeout_o && ctrl_ff.status)
		else $error("force source did not raise timeout");
	rsvd_zero_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		wr_ctrl |=> ctrl_ff.rsvd_hi == CTRL_RSVD_VAL && !ctrl_ff.rsvd1)
		else $error("reserved control bits took a value");
	status_clear_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		wr_ctrl && !wbyte[CTRL_STATUS_BIT] && !timeout_evt |=> !ctrl_ff.status)
		else $error("status not cleared by zero write");
	bus_answer_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		bus_state_ff == BUS_IDLE && (avs_read_i || avs_write_i) |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
		else $error("bus answer not one cycle after request");
	irq_level_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		$past(|(irq_sts_ff & irq_mask_ff)) == irq_o)
		else $error("interrupt level does not follow masked status");

	// register and event checks
	kbd_event_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		kbd_pulse |=> timeout_o && ctrl_ff.status && irq_sts_ff[IRQ_KBD_BIT])
		else $error("keyboard pulse did not raise timeout");
	kbd_gate_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		kbd_pulse |-> $past(ctrl_ff.kbd_en))
		else $error("keyboard pulse while disabled");
	force_timeout_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		wr_ctrl && wbyte[CTRL_FORCE_BIT] |-> ##2 timeout_o)
		else $error("force write gave no timeout");
	status_hold_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		ctrl_ff.status && !wr_ctrl |=> ctrl_ff.status)
		else $error("status dropped without a write");
	status_rise_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		$rose(ctrl_ff.status) |-> $past(timeout_evt || (wr_ctrl && wbyte[CTRL_STATUS_BIT])))
		else $error("status set without event or write");
	count_off_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		value_ff == VALUE_DISABLED |-> !expire)
		else $error("expiry with timeout value zero");
	value_store_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		wr_value |=> value_ff == $past(wbyte))
		else $error("timeout value not stored");
	units_store_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		wr_units |=> units_ff[UNITS_SEC_BIT] == $past(wbyte[UNITS_SEC_BIT]))
		else $error("unit select not stored");
	enable_store_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		wr_ctrl |=> ctrl_ff.kbd_en == $past(wbyte[CTRL_KBD_EN_BIT]))
		else $error("keyboard enable not stored");
	expire_event_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		expire |=> timeout_o && ctrl_ff.status)
		else $error("counted expiry did not raise timeout");
	no_source_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		!timeout_evt |=> !timeout_o)
		else $error("timeout without a source");
	kbd_once_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		kbd_pulse |=> !kbd_pulse)
		else $error("keyboard pulse longer than one cycle");
	kbd_sts_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		irq_evt[IRQ_KBD_BIT] |=> irq_sts_ff[IRQ_KBD_BIT])
		else $error("keyboard edge did not set status");
	sts_clear_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		wr_sts && wbyte[IRQ_TIMEOUT_BIT] && !irq_evt[IRQ_TIMEOUT_BIT] |=> !irq_sts_ff[IRQ_TIMEOUT_BIT])
		else $error("timeout status not cleared by one");
	mask_store_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		wr_mask |=> irq_mask_ff == $past(wbyte[IRQ_BITS-1:0]))
		else $error("interrupt mask not stored");
	read_upper_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		avs_read_i && !avs_waitrequest_o |-> avs_readdata_o[31:8] == 24'h00_0000)
		else $error("read data upper lanes not zero");
	read_capture_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		bus_state_ff == BUS_IDLE && avs_read_i |=> avs_readdata_o == {24'h00_0000, $past(rd_mux)})
		else $error("read data not the addressed register");
	wait_high_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		bus_state_ff == BUS_ACK |=> avs_waitrequest_o)
		else $error("waitrequest low for more than one cycle");
endmodule
`default_nettype wire

// *** dv/kbd_line_model.sv ***
// keyboard controller output line model, one high pulse per request
`timescale 1ns/1ps
`default_nettype none
module kbd_line_model (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic srst_i,
	// request
	input wire logic fire_i,
	input wire logic [7:0] high_cycles_i,
	// line
	output logic keyboard_force_line_o
);
	logic [7:0] left_ff;
	// never shorter than 1us (20 cycles): the detector may miss shorter pulses
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			left_ff <= 8'h00;
		end else if (fire_i) begin
			left_ff <= (high_cycles_i < 8'h14) ? 8'h14 : high_cycles_i;
		end else if (left_ff != 8'h00) begin
			left_ff <= left_ff - 8'h01;
		end
	end
	// line idles low between pulses
	assign keyboard_force_line_o = (left_ff != 8'h00);
endmodule
`default_nettype wire

// *** dv/watchdog_control_register_bench.sv ***
// self-checking bench for the watchdog control block
`timescale 1ns/1ps
`default_nettype none
module watchdog_control_register_bench;
	import watchdog_pkg::*;
	localparam int LIMIT = 20000;
	logic ref_clk_i = 1'b0;
	logic srst_i = 1'b1;
	logic [7:0] avs_address_i = 8'h00;
	logic avs_read_i = 1'b0;
	logic avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h0000_0000;
	logic [3:0] avs_byteenable_i = 4'hf;
	logic [31:0] avs_readdata_o;
	logic avs_waitrequest_o;
	logic keyboard_force_line_i;
	logic timeout_o;
	logic irq_o;
	logic fire = 1'b0;
	logic [7:0] high_len = 8'h14;
	logic [7:0] exp_q[$];
	int err_count = 0;
	int samples_checked = 0;
	int pulses = 0;
	int cyc = 0;

	always #25 ref_clk_i = ~ref_clk_i;

	watchdog_control_register #(.SEC_CYCLES_P(10)) watchdog_control_register_inst (
		.ref_clk_i(ref_clk_i), .srst_i(srst_i), .avs_address_i(avs_address_i),
		.avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
		.avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
		.avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
		.keyboard_force_line_i(keyboard_force_line_i), .timeout_o(timeout_o), .irq_o(irq_o));

	kbd_line_model kbd_line_model_inst (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .fire_i(fire),
		.high_cycles_i(high_len), .keyboard_force_line_o(keyboard_force_line_i));

	task automatic print_verdict;
		$display("checks %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// request held until the edge that sees waitrequest low
	task automatic bus_wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] be);
		@(posedge ref_clk_i);
		avs_address_i <= a;
		avs_writedata_i <= {24'h00_0000, d};
		avs_byteenable_i <= be;
		avs_write_i <= 1'b1;
		do @(posedge ref_clk_i); while (avs_waitrequest_o !== 1'b0);
		avs_write_i <= 1'b0;
	endtask

	// expectation goes on the queue, the monitor compares it
	task automatic bus_rd(input logic [7:0] a, input logic [7:0] exp);
		exp_q.push_back(exp);
		@(posedge ref_clk_i);
		avs_address_i <= a;
		avs_read_i <= 1'b1;
		do @(posedge ref_clk_i); while (avs_waitrequest_o !== 1'b0);
		avs_read_i <= 1'b0;
	endtask

	task automatic kick(input logic [7:0] len);
		@(posedge ref_clk_i);
		fire <= 1'b1;
		high_len <= len;
		@(posedge ref_clk_i);
		fire <= 1'b0;
		repeat (int'(len) + 10) @(posedge ref_clk_i);
	endtask

	always @(posedge ref_clk_i) begin
		if (avs_read_i === 1'b1 && avs_waitrequest_o === 1'b0) begin
			check(avs_readdata_o, {24'h00_0000, exp_q.pop_front()});
		end
		if (timeout_o === 1'b1) begin
			pulses++;
		end
		cyc++;
		if (cyc == LIMIT) begin
			err_count++;
			print_verdict();
		end
	end

	initial begin
		void'($urandom(27));
		repeat (20) @(posedge ref_clk_i);
		srst_i <= 1'b0;
		bus_rd(REG_UNITS_IDX, UNITS_RESET);
		bus_rd(REG_VALUE_IDX, VALUE_RESET);
		bus_rd(REG_CTRL_IDX, 8'h00);
		bus_rd(REG_IRQ_STS_IDX, 8'h00);
		bus_rd(REG_IRQ_MASK_IDX, 8'h00);
		bus_rd(8'h10, 8'h00);
		// byte lane 0 off: write ignored
		bus_wr(REG_CTRL_IDX, 8'h04, 4'he);
		bus_rd(REG_CTRL_IDX, 8'h00);
		bus_wr(REG_CTRL_IDX, 8'h04, 4'hf);
		repeat (4) @(posedge ref_clk_i);
		bus_rd(REG_CTRL_IDX, 8'h01);
		check(pulses, 1);
		bus_wr(REG_CTRL_IDX, 8'h00, 4'hf);
		bus_rd(REG_CTRL_IDX, 8'h00);
		bus_wr(REG_CTRL_IDX, 8'h01, 4'hf);
		bus_rd(REG_CTRL_IDX, 8'h01);
		bus_wr(REG_CTRL_IDX, 8'h00, 4'hf);
		kick(8'h1e);
		bus_rd(REG_CTRL_IDX, 8'h00);
		check(pulses, 1);
		bus_wr(REG_CTRL_IDX, 8'h08, 4'hf);
		bus_rd(REG_CTRL_IDX, 8'h08);
		kick(8'h14);
		bus_rd(REG_CTRL_IDX, 8'h09);
		check(pulses, 2);
		kick(8'h14 + 8'($urandom % 200));
		check(pulses, 3);
		bus_rd(REG_IRQ_STS_IDX, 8'h03);
		bus_wr(REG_IRQ_MASK_IDX, 8'h02, 4'hf);
		repeat (3) @(posedge ref_clk_i);
		check(irq_o, 1'b1);
		bus_wr(REG_IRQ_STS_IDX, 8'h03, 4'hf);
		repeat (3) @(posedge ref_clk_i);
		check(irq_o, 1'b0);
		bus_rd(REG_IRQ_STS_IDX, 8'h00);
		bus_wr(REG_CTRL_IDX, 8'h0c, 4'hf);
		repeat (4) @(posedge ref_clk_i);
		check(pulses, 4);
		bus_rd(REG_CTRL_IDX, 8'h09);
		bus_wr(REG_CTRL_IDX, 8'hf8, 4'hf);
		bus_rd(REG_CTRL_IDX, 8'h08);
		// seconds with ten-cycle second: two units are 20 cycles
		bus_wr(REG_UNITS_IDX, 8'h80, 4'hf);
		bus_rd(REG_UNITS_IDX, 8'h80);
		bus_wr(REG_VALUE_IDX, 8'h02, 4'hf);
		bus_rd(REG_VALUE_IDX, 8'h02);
		repeat (40) @(posedge ref_clk_i);
		check(pulses, 5);
		bus_rd(REG_CTRL_IDX, 8'h09);
		bus_wr(REG_VALUE_IDX, VALUE_DISABLED, 4'hf);
		repeat (300) @(posedge ref_clk_i);
		check(pulses, 5);
		// minutes: one unit is 600 cycles
		bus_wr(REG_UNITS_IDX, 8'h00, 4'hf);
		bus_wr(REG_VALUE_IDX, 8'h01, 4'hf);
		repeat (400) @(posedge ref_clk_i);
		check(pulses, 5);
		repeat (300) @(posedge ref_clk_i);
		check(pulses, 6);
		print_verdict();
	end
endmodule
`default_nettype wire
